// [design/level_arbiter.v]
// level arbiter: picks the highest-priority asserted request
`include "pic_defines.vh"
module level_arbiter #(
  parameter N = `NUM_SOURCES
) (
  // clock and reset
  input  wire           mclk,
  input  wire           reset_n,
  // request lines and their level fields
  input  wire [N-1:0]   requests,
  input  wire [2*N-1:0] level_fields,
  // registered winner
  output reg            win_valid,
  output reg  [1:0]     win_level,
  output reg  [3:0]     win_index
);
  // field decode: 00 level one, 01 level two, 1x level three
  function [1:0] decode_level;
    input [1:0] field;
    begin
      if (field[1])
        decode_level = `LEVEL_THREE;
      else if (field[0])
        decode_level = `LEVEL_TWO;
      else
        decode_level = `LEVEL_ONE;
    end
  endfunction

  reg       next_valid; // any request that can ever be taken
  reg [1:0] next_level; // best level found so far
  reg [3:0] next_index; // source holding it
  reg [1:0] lvl;        // decoded level of the source under test
  integer   i;

  // ascending scan with strict compare keeps the lowest index on a tie
  always @* begin
    next_valid = 1'b0;
    next_level = `LEVEL_NONE;
    next_index = 4'h0;
    lvl        = `LEVEL_NONE;
    for (i = 0; i < N; i = i + 1) begin
      lvl = decode_level(level_fields[2*i +: 2]);
      if (requests[i] && lvl != `LEVEL_THREE &&
          (!next_valid || lvl < next_level)) begin
        next_valid = 1'b1;
        next_level = lvl;
        next_index = i[3:0];
      end
    end
  end

  // winner registered every cycle
  always @(posedge mclk) begin
    if (!reset_n) begin
      win_valid <= 1'b0;
      win_level <= `LEVEL_NONE;
      win_index <= 4'h0;
    end else begin
      win_valid <= next_valid;
      win_level <= next_level;
      win_index <= next_index;
    end
  end
endmodule

// [design/priority_interrupt_controller.v]
// interrupt controller with cpu acceptance, entry and return sequencer
`include "pic_defines.vh"
module priority_interrupt_controller #(
  parameter N           = `NUM_SOURCES,
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3
) (
  // clock and reset
  input  wire          mclk,
  input  wire          reset_n,
  // peripheral side
  input  wire [N-1:0]  cause_event,
  input  wire [N-1:0]  pending_clear,
  input  wire [N-1:0]  enable_set,
  input  wire [N-1:0]  enable_clear,
  output wire [N-1:0]  peripheral_request,
  output wire [N-1:0]  pending_flag,
  output wire [N-1:0]  request_enable_flag,
  // level setting register writes
  input  wire [2:0]    level_write,
  input  wire [7:0]    level_write_data,
  // cpu condition codes
  input  wire          global_enable,
  input  wire          cpu_level_write,
  input  wire [1:0]    cpu_level_data,
  output wire          cpu_level_bit_high,
  output wire          cpu_level_bit_low,
  // cpu instruction flow
  input  wire          instr_last_cycle,
  input  wire          return_from_interrupt_instr,
  input  wire          muldiv_in_use,
  input  wire [15:0]   program_counter,
  input  wire [15:0]   program_status_word,
  input  wire          standby,
  // entry results
  output reg           accept,
  output reg  [3:0]    accepted_index,
  output reg  [1:0]    accepted_level,
  output reg  [15:0]   vector_address,
  output reg           handler_start,
  output wire          cpu_hold,
  output wire          wake,
  // return results
  output reg           resume_valid,
  output reg  [15:0]   resume_pc,
  output reg  [15:0]   resume_psw,
  // status
  output reg           stack_error,
  output reg           latency_over,
  output wire [1:0]    forwarded_level
);
  // sequencer states, one-hot
  localparam S_IDLE   = 4'h1;
  localparam S_ENTRY  = 4'h2;
  localparam S_RET_PS = 4'h4;
  localparam S_RET_PC = 4'h8;

  // vector entry of a source, top entry first
  function [15:0] vector_of;
    input [3:0] idx;
    begin
      vector_of = `VECTOR_TOP - ({12'h000, idx} * `VECTOR_STEP);
    end
  endfunction

  reg  [7:0]       level_reg_1;      // sources 0..3
  reg  [7:0]       level_reg_2;      // sources 4..7
  reg  [7:0]       level_reg_3;      // sources 8..11
  reg  [N-1:0]     pending;          // pending flags
  reg  [N-1:0]     enables;          // request enable flags
  reg  [1:0]       cpu_level;        // condition code level field
  reg  [3:0]       state;            // sequencer state
  reg  [3:0]       step;             // entry cycle counter
  reg  [SP_W:0]    sp;               // stack fill count
  reg  [15:0]      pc_stack [0:STACK_DEPTH-1]; // saved counters
  reg  [15:0]      ps_stack [0:STACK_DEPTH-1]; // saved status words
  reg  [7:0]       wait_count;       // cycles an acceptable request waited
  wire             win_valid;        // arbiter has a candidate
  wire [1:0]       win_level;        // its level
  wire [3:0]       win_index;        // its source
  wire             acceptable;       // candidate passes cpu checks
  wire             stack_full;       // no room for another nest
  wire [SP_W-1:0]  top;              // index of the newest entry
  wire [7:0]       latency_limit;    // worst latency for this program
  wire [2*N-1:0]   level_fields;     // all level fields in source order

  assign level_fields = {level_reg_3, level_reg_2, level_reg_1};
  assign stack_full   = (sp == STACK_DEPTH[SP_W:0]);
  assign top          = sp[SP_W-1:0] - {{(SP_W-1){1'b0}}, 1'b1};

  // request is pending and enabled, held while both are set
  assign peripheral_request  = pending & enables;
  assign pending_flag        = pending;
  assign request_enable_flag = enables;
  assign cpu_level_bit_high  = cpu_level[1];
  assign cpu_level_bit_low   = cpu_level[0];
  assign forwarded_level     = win_valid ? win_level : `LEVEL_NONE;

  // strict compare also rules out level three and a field of 00
  assign acceptable = win_valid && global_enable &&
                      (win_level != `LEVEL_THREE) &&
                      (win_level < cpu_level);

  // sequencer stalls the cpu while it owns the stack
  assign cpu_hold = (state != S_IDLE);

  // standby ends as soon as a takeable request shows up
  assign wake = standby && acceptable;

  // longest instruction plus entry time bounds the latency
  assign latency_limit = muldiv_in_use ? `WORST_LATENCY :
                         (`LONGEST_NO_MULDIV + {4'h0, `ENTRY_CYCLES});

  // arbiter over the twelve sources
  level_arbiter #(
    .N (N)
  ) u_arbiter (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .requests     (peripheral_request),
    .level_fields (level_fields),
    .win_valid    (win_valid),
    .win_level    (win_level),
    .win_index    (win_index)
  );

  // level setting registers, reset to level three everywhere
  always @(posedge mclk) begin
    if (!reset_n) begin
      level_reg_1 <= `LEVEL_REG_RESET;
      level_reg_2 <= `LEVEL_REG_RESET;
      level_reg_3 <= `LEVEL_REG_RESET;
    end else begin
      // each strobe loads one register
      if (level_write[0])
        level_reg_1 <= level_write_data;
      if (level_write[1])
        level_reg_2 <= level_write_data;
      if (level_write[2])
        level_reg_3 <= level_write_data;
    end
  end

  // pending flags: a new cause beats a clear in the same cycle
  always @(posedge mclk) begin
    if (!reset_n)
      pending <= {N{1'b0}};
    else
      pending <= (pending & ~pending_clear) | cause_event;
  end

  // enable flags: set beats clear, all off after reset
  always @(posedge mclk) begin
    if (!reset_n)
      enables <= {N{1'b0}};
    else
      enables <= (enables & ~enable_clear) | enable_set;
  end

  // stack writes during entry; no reset needed for storage
  always @(posedge mclk) begin
    if (state == S_ENTRY && step == `STEP_SAVE_PC)
      pc_stack[sp[SP_W-1:0]] <= program_counter;
    // status saved with the level field the cpu held before entry
    if (state == S_ENTRY && step == `STEP_SAVE_PS) begin
      ps_stack[sp[SP_W-1:0]] <= program_status_word;
      ps_stack[sp[SP_W-1:0]][`PS_LEVEL_HI:`PS_LEVEL_LO] <= cpu_level;
    end
  end

  // acceptance, entry and return sequencer
  always @(posedge mclk) begin
    if (!reset_n) begin
      state          <= S_IDLE;
      step           <= 4'h0;
      sp             <= {(SP_W+1){1'b0}};
      cpu_level      <= `CPU_LEVEL_RESET;
      accept         <= 1'b0;
      accepted_index <= 4'h0;
      accepted_level <= `LEVEL_NONE;
      vector_address <= 16'h0000;
      handler_start  <= 1'b0;
      resume_valid   <= 1'b0;
      resume_pc      <= 16'h0000;
      resume_psw     <= 16'h0000;
      stack_error    <= 1'b0;
    end else begin
      // pulses default low
      accept        <= 1'b0;
      handler_start <= 1'b0;
      resume_valid  <= 1'b0;
      case (state)
        S_IDLE: begin
          // only the last cycle of an instruction may be interrupted
          if (instr_last_cycle && acceptable && !stack_full) begin
            accept         <= 1'b1;
            accepted_index <= win_index;
            accepted_level <= win_level;
            step           <= `STEP_SAVE_PC;
            state          <= S_ENTRY;
          end else if (instr_last_cycle && acceptable) begin
            // nest too deep: refuse and flag
            stack_error <= 1'b1;
          end else if (return_from_interrupt_instr) begin
            if (sp == {(SP_W+1){1'b0}})
              stack_error <= 1'b1;
            else
              state <= S_RET_PS;
          end else if (cpu_level_write) begin
            // software may mask nesting by writing the level field
            cpu_level <= cpu_level_data;
          end
        end
        S_ENTRY: begin
          // accumulators are left to the handler to save
          step <= step + 4'h1;
          if (step == `STEP_SAVE_PS)
            sp <= sp + {{SP_W{1'b0}}, 1'b1};
          if (step == `STEP_VECTOR)
            vector_address <= vector_of(accepted_index);
          if (step == `STEP_LEVEL)
            cpu_level <= accepted_level;
          // ninth cycle ends the preparation
          if (step == `ENTRY_CYCLES) begin
            handler_start <= 1'b1;
            step          <= 4'h0;
            state         <= S_IDLE;
          end
        end
        S_RET_PS: begin
          // status word comes off first
          resume_psw <= ps_stack[top];
          cpu_level  <= ps_stack[top][`PS_LEVEL_HI:`PS_LEVEL_LO];
          state      <= S_RET_PC;
        end
        S_RET_PC: begin
          // then the counter, and the frame is released
          resume_pc    <= pc_stack[top];
          resume_valid <= 1'b1;
          sp           <= sp - {{SP_W{1'b0}}, 1'b1};
          state        <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
          step  <= 4'h0;
        end
      endcase
    end
  end

  // latency watch: counts from a takeable request to handler start
  always @(posedge mclk) begin
    if (!reset_n) begin
      wait_count   <= 8'h00;
      latency_over <= 1'b0;
    end else if (handler_start || (!acceptable && state == S_IDLE)) begin
      wait_count <= 8'h00;
    end else if (acceptable || state == S_ENTRY) begin
      if (wait_count != 8'hFF)
        wait_count <= wait_count + 8'h01;
      if (wait_count >= latency_limit)
        latency_over <= 1'b1;
    end
  end
endmodule

// [shared/pic_defines.vh]
// constants shared by the interrupt controller and its level arbiter
// Function
// - after reset every request is disabled
// - levels 1,2,3; 1 highest; 3 never accepted
// - cause sets pending; request needs enable too
// - controller forwards highest asserted request level
// - equal levels resolved by fixed source order
// - accept if level below cpu field, enabled
// - accept: save counter, status, vector, load level
// - return pops status first, then counter
// - return restores level field and condition codes
// - acceptance leaves pending; handler must clear it
// - same or lower level waits for handler end
// - strictly higher level nests into running handler
// - no acceptance when disabled or level 00
// - sample only in final instruction cycle
// - entry preparation takes exactly nine cycles
// - worst latency thirty cycles with divide
// - without multiply/divide longest instruction six cycles
// - accumulators not saved; software saves them
// - accepted request wakes cpu from standby
// - twelve sources, each with own level
// - equal levels: line zero wins, ascending order
// - field 00 level1, 01 level2, 1x level3
// - vectors run downward from top entry
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
`define NUM_SOURCES      12
`define LEVEL_REG_RESET  8'hFF
`define CPU_LEVEL_RESET  2'h3
`define LEVEL_ONE        2'h1
`define LEVEL_TWO        2'h2
`define LEVEL_THREE      2'h3
`define LEVEL_NONE       2'h0
`define VECTOR_TOP       16'hFFFA
`define VECTOR_STEP      16'h0002
`define PS_LEVEL_LO      4
`define PS_LEVEL_HI      5
`define ENTRY_CYCLES     4'h9
`define STEP_SAVE_PC     4'h1
`define STEP_SAVE_PS     4'h2
`define STEP_VECTOR      4'h3
`define STEP_LEVEL       4'h4
`define LONGEST_INSTR    8'h15
`define LONGEST_NO_MULDIV 8'h06
`define WORST_LATENCY    8'h1E
`endif

// [test/cpu_core_model.sv]
// cpu core model: instruction flow, counter and status word
module cpu_core_model #(parameter LEN = 3, parameter PSW = 16'h800F) (
  input  wire logic        mclk,
  input  wire logic        cpu_hold,
  output logic             instr_last_cycle,
  output logic [15:0]      program_counter,
  output logic [15:0]      program_status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0; // cycle within instruction, LEN kept at 6 or less
  initial program_counter = 16'h0100;
  assign program_status_word = PSW;
  // final cycle flagged only while executing, never mid instruction
  assign instr_last_cycle = (cnt == LEN - 1) && !cpu_hold;
  // frozen while the controller holds the core
  always @(negedge mclk) begin
    if (!cpu_hold) begin
      cnt <= (cnt == LEN - 1) ? 3'h0 : cnt + 3'h1;
      if (cnt == LEN - 1) program_counter <= program_counter + 16'h0001;
    end
  end
endmodule

// [test/pic_checker_sva.sv]
// port-level assertions for the priority interrupt controller
module pic_checker #(parameter N = 12) (
  // clock and reset
  input wire logic         mclk, reset_n,
  // peripheral side
  input wire logic [N-1:0] pending_clear, peripheral_request, pending_flag, request_enable_flag,
  // cpu side
  input wire logic         global_enable, instr_last_cycle, standby, cpu_level_bit_high, cpu_level_bit_low,
  // entry and return results
  input wire logic         accept, handler_start, cpu_hold, wake, resume_valid,
  input wire logic [3:0]   accepted_index,
  input wire logic [1:0]   accepted_level, forwarded_level,
  input wire logic [15:0]  vector_address, resume_psw
);
  timeunit 1ns;
  timeprecision 1ps;
  // current cpu level field
  wire logic [1:0] lvl;
  assign lvl = {cpu_level_bit_high, cpu_level_bit_low};
  // pending clears seen one cycle earlier, lined up with the accept pulse
  logic [N-1:0] clr_d;
  always @(posedge mclk) clr_d <= pending_clear;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_clears: assert property (disable iff (1'b0) !reset_n |=> pending_flag == 0 && request_enable_flag == 0 && lvl == 2'h3)
    else $error("flags or level not cleared by reset");
  a_forward_range: assert property (forwarded_level != 2'h3)
    else $error("level three forwarded");
  a_request_gate: assert property (peripheral_request == (pending_flag & request_enable_flag))
    else $error("request not pending and enable");
  a_accept_sample: assert property (accept |-> $past(instr_last_cycle) && $past(global_enable))
    else $error("accept outside final cycle or disabled");
  a_accept_rank: assert property (accept |-> accepted_level == $past(forwarded_level) && accepted_level != 2'h0 && accepted_level < $past(lvl))
    else $error("accepted level does not outrank cpu level");
  a_entry_nine: assert property (accept |-> cpu_hold [*8] ##1 cpu_hold ##1 (!cpu_hold && handler_start))
    else $error("entry not nine cycles");
  a_vector_entry: assert property (handler_start |-> vector_address == 16'hFFFA - {11'h000, accepted_index, 1'b0})
    else $error("wrong vector address");
  a_level_load: assert property (handler_start |-> lvl == accepted_level)
    else $error("level field not loaded");
  a_pending_kept: assert property (accept && !clr_d[accepted_index] |-> pending_flag[accepted_index])
    else $error("pending cleared by acceptance");
  a_return_level: assert property (resume_valid |-> lvl == resume_psw[5:4])
    else $error("level not restored on return");
  a_wake_gate: assert property (wake == (standby && global_enable && forwarded_level != 2'h0 && forwarded_level < lvl))
    else $error("wake does not follow standby and a takeable request");
  c_accept: cover property (accept);
  c_nested: cover property (handler_start && accepted_level == 2'h1);
  c_return: cover property (resume_valid);
  c_wake: cover property (wake);
endmodule
bind priority_interrupt_controller pic_checker #(.N(N)) checker_i (.mclk(mclk), .reset_n(reset_n),
  .pending_clear(pending_clear), .peripheral_request(peripheral_request), .pending_flag(pending_flag),
  .request_enable_flag(request_enable_flag), .global_enable(global_enable), .instr_last_cycle(instr_last_cycle),
  .standby(standby), .cpu_level_bit_high(cpu_level_bit_high), .cpu_level_bit_low(cpu_level_bit_low),
  .accept(accept), .handler_start(handler_start), .cpu_hold(cpu_hold), .wake(wake), .resume_valid(resume_valid),
  .accepted_index(accepted_index), .accepted_level(accepted_level), .forwarded_level(forwarded_level),
  .vector_address(vector_address), .resume_psw(resume_psw));

// [test/priority_interrupt_controller_bench.sv]
// self-checking bench for the priority interrupt controller
module priority_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, global_enable = 0, cpu_level_write = 0, ret = 0, standby = 0, muldiv = 0;
  logic [11:0] cause_event = 0, pending_clear = 0, enable_set = 0, enable_clear = 0;
  logic [11:0] peripheral_request, pending_flag, request_enable_flag;
  logic [2:0] level_write = 0;
  logic [7:0] level_write_data = 0;
  logic [1:0] cpu_level_data = 0, accepted_level, forwarded_level;
  logic hi, lo, last, accept, handler_start, cpu_hold, wake, resume_valid, stack_error, latency_over;
  logic [3:0] accepted_index;
  logic [15:0] pc, psw, vector_address, resume_pc, resume_psw, pc1, pc2;
  int error_cnt = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  cpu_core_model cpu (.mclk(mclk), .cpu_hold(cpu_hold), .instr_last_cycle(last), .program_counter(pc),
    .program_status_word(psw));
  priority_interrupt_controller DUT (.mclk(mclk), .reset_n(reset_n), .cause_event(cause_event),
    .pending_clear(pending_clear), .enable_set(enable_set), .enable_clear(enable_clear),
    .peripheral_request(peripheral_request), .pending_flag(pending_flag), .request_enable_flag(request_enable_flag),
    .level_write(level_write), .level_write_data(level_write_data), .global_enable(global_enable),
    .cpu_level_write(cpu_level_write), .cpu_level_data(cpu_level_data), .cpu_level_bit_high(hi),
    .cpu_level_bit_low(lo), .instr_last_cycle(last), .return_from_interrupt_instr(ret), .muldiv_in_use(muldiv),
    .program_counter(pc), .program_status_word(psw), .standby(standby), .accept(accept),
    .accepted_index(accepted_index), .accepted_level(accepted_level), .vector_address(vector_address),
    .handler_start(handler_start), .cpu_hold(cpu_hold), .wake(wake), .resume_valid(resume_valid),
    .resume_pc(resume_pc), .resume_psw(resume_psw), .stack_error(stack_error), .latency_over(latency_over),
    .forwarded_level(forwarded_level));
  // compare and count
  task chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // wait for accept (0), handler start (1) or resume (2), bounded
  task wait_for(input int w);
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk);
      if ((w == 0 ? accept : w == 1 ? handler_start : resume_valid) === 1'b1) return;
    end
    chk("wait timeout", 16'h0001, 16'h0000);
    stop_test();
  endtask
  // no acceptance for n cycles
  task no_acc(input int n);
    repeat (n) begin
      @(negedge mclk);
      chk("accept", accept, 0);
    end
  endtask
  task t_config;
    chk("cpu level", {hi, lo}, 2'h3);
    cause_event = 12'h002;
    @(negedge mclk) cause_event = 0;
    chk("pending", pending_flag, 12'h002);
    chk("request", peripheral_request, 0);
    level_write = 3'h5;
    level_write_data = 8'hC4;
    @(negedge mclk) level_write = 3'h4;
    level_write_data = 8'h3F;
    @(negedge mclk) level_write = 0;
    enable_set = 12'hFFF;
    cause_event = 12'h008;
    @(negedge mclk) enable_set = 0;
    cause_event = 0;
    chk("request", peripheral_request, 12'h00A);
    no_acc(3);
    chk("forwarded", forwarded_level, 2'h2);
    pending_clear = 12'h008;
    @(negedge mclk) pending_clear = 0;
    $display("test config done");
  endtask
  task t_nest;
    standby = 1;
    no_acc(12);
    chk("wake", wake, 0);
    global_enable = 1;
    wait_for(0);
    pc1 = pc;
    chk("wake", wake, 1);
    standby = 0;
    chk("index", accepted_index, 4'h1);
    wait_for(1);
    chk("vector", vector_address, 16'hFFF8);
    chk("cpu level", {hi, lo}, 2'h2);
    chk("pending", pending_flag[1], 1);
    no_acc(10);
    cause_event = 12'h801;
    @(negedge mclk) cause_event = 0;
    wait_for(0);
    pc2 = pc;
    chk("index", accepted_index, 4'h0);
    wait_for(1);
    chk("vector", vector_address, 16'hFFFA);
    chk("cpu level", {hi, lo}, 2'h1);
    no_acc(10);
    pending_clear = 12'hFFF;
    ret = 1;
    @(negedge mclk) pending_clear = 0;
    ret = 0;
    wait_for(2);
    chk("resume pc", resume_pc, pc2);
    chk("resume psw", resume_psw, {psw[15:6], 2'h2, psw[3:0]});
    chk("cpu level", {hi, lo}, 2'h2);
    ret = 1;
    @(negedge mclk) ret = 0;
    wait_for(2);
    chk("resume pc", resume_pc, pc1);
    chk("cpu level", {hi, lo}, 2'h3);
    $display("test nest done");
  endtask
  task t_zero;
    cpu_level_write = 1;
    @(negedge mclk) cpu_level_write = 0;
    chk("cpu level", {hi, lo}, 2'h0);
    cause_event = 12'h001;
    @(negedge mclk) cause_event = 0;
    no_acc(12);
    enable_clear = 12'hFFF;
    @(negedge mclk) enable_clear = 0;
    chk("request", peripheral_request, 0);
    chk("pending", pending_flag, 12'h001);
    chk("stack error", stack_error, 0);
    chk("latency over", latency_over, 0);
    $display("test zero done");
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1;
    t_config();
    t_nest();
    t_zero();
    stop_test();
  end
endmodule
